/* File: logic/clk_select_pkg.sv */
// constants, field layouts and carrier types of the clock source selector
// Operation
// - one fast and one slow source are always selected, never none.
// - software switches system clock between fast and slow sources at run time.
// - fast source is internal rc or crystal, chosen by static configuration.
// - crystal range option: high range at or above 1MHz, low below.
// - internal fast rc selected releases the fast crystal pins as gpio.
// - slow code 0101010 picks rc, 1010101 crystal, anything else resets.
// - slow crystal pins are gpio unless the slow crystal feeds a clock.
// - bit 7 picks slow crystal mode: 0 quick start, 1 low power.
// - after power-on the low power bit is zero, quick start mode.
// - slow crystal runs normally in both modes; only current and start differ.
// - slow crystal clock is invalid until a start-up delay has passed.
// - slow clock stays available while the system clock is stopped.
// - select bit zero: codes 000,001 slow; 010 to 111 fast /64 to /2.
// - slow ready low in deep sleep; high after 1024 crystal or 2 rc ticks.
package clk_select_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	// register byte addresses
	localparam logic [ADDR_W-1:0] SLOW_SEL_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] SYS_MODE_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] CFG_STAT_ADDR = 12'h008;
	// slow source codes
	localparam logic [6:0] CODE_SLOW_RC = 7'h2a;
	localparam logic [6:0] CODE_SLOW_XTAL = 7'h55;
	// reset values
	localparam logic [7:0] SLOW_SEL_RESET = 8'h2a;
	localparam logic [2:0] DIVIDER_RESET = 3'h0;
	localparam logic IDLE_EN_RESET = 1'b1;
	localparam logic FAST_SEL_RESET = 1'b1;
	// system mode register field positions, and the low power bit of the slow select register
	localparam int DIV_LSB = 5;
	localparam int SLOW_READY_POS = 3;
	localparam int FAST_READY_POS = 2;
	localparam int IDLE_EN_POS = 1;
	localparam int FAST_SEL_POS = 0;
	localparam int LOW_POWER_POS = 7;
	// divider codes at and above this pick the fast clock
	localparam logic [2:0] FIRST_FAST_CODE = 3'h2;
	// slow ready delays in slow ticks
	localparam logic [10:0] XTAL_READY_TICKS = 11'h400;
	localparam logic [10:0] RC_READY_TICKS = 11'h002;
	// fast ticks before the fast source counts as ready
	localparam logic [3:0] FAST_READY_TICKS = 4'h8;

	typedef struct packed
	{
		logic [2:0] divider;
		logic idle_en;
		logic fast_sel;
	} sys_mode_s;

	typedef struct packed
	{
		logic low_power;
		logic [6:0] code;
	} slow_sel_s;

	typedef struct packed
	{
		logic slow;
		logic [2:0] divider;
	} clk_choice_s;
endpackage : clk_select_pkg

/* File: logic/clk_source_select.sv */
// system clock source selection, dividers, ready flags and pin roles
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module clk_source_select
	import clk_select_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [DATA_W-1:0] pwdata_in,
	output logic [DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic internal_fast_rc_osc_in,
	input wire logic external_fast_crystal_in,
	input wire logic internal_slow_rc_osc_in,
	input wire logic external_slow_crystal_in,
	input wire logic fast_src_crystal_cfg_in,
	input wire logic fast_xtal_high_range_cfg_in,
	input wire logic cpu_halt_in,
	input wire logic deep_sleep_in,
	output logic sys_clk_en_out,
	output logic slow_clk_en_out,
	output logic fast_crystal_pins_gpio_out,
	output logic fast_xtal_high_range_out,
	output logic slow_crystal_pins_gpio_out,
	output logic slow_crystal_low_power_out,
	output logic device_reset_req_out
);

	// decode table for the divider limit: ticks per output pulse minus one
	function automatic logic [5:0] div_limit(input clk_choice_s c);
		logic [5:0] lim;
		lim = 6'h00;
		case (c.divider)
			3'h2: lim = 6'h3f;
			3'h3: lim = 6'h1f;
			3'h4: lim = 6'h0f;
			3'h5: lim = 6'h07;
			3'h6: lim = 6'h03;
			3'h7: lim = 6'h01;
			default: lim = 6'h00;
		endcase
		return lim;
	endfunction : div_limit

	// map register fields onto the clock choice; select bit set means fH
	function automatic clk_choice_s choice_of(input sys_mode_s m);
		clk_choice_s c;
		c.slow = ~m.fast_sel && (m.divider < FIRST_FAST_CODE);
		c.divider = m.fast_sel ? 3'h0 : m.divider;
		return c;
	endfunction : choice_of

	sys_mode_s sys_mode;
	slow_sel_s slow_sel;
	clk_choice_s active;
	logic [2:0] fast_sync;
	logic [2:0] slow_rc_sync;
	logic [2:0] slow_xt_sync;
	logic [1:0] cfg_sync;
	logic [1:0] cfg_hold;
	logic cfg_taken;
	logic [1:0] cfg_age;
	logic [5:0] div_cnt;
	logic [10:0] ready_cnt;
	logic slow_ready;
	logic [3:0] fast_cnt;
	logic fast_ready;
	logic [6:0] last_code;

	// raw sampling of the oscillator pins: two stages before use
	wire fast_raw = cfg_hold[0] ? external_fast_crystal_in
		: internal_fast_rc_osc_in;
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fast_sync <= 3'h0;
			slow_rc_sync <= 3'h0;
			slow_xt_sync <= 3'h0;
			cfg_sync <= 2'h0;
		end
		else
		begin
			fast_sync <= {fast_sync[1:0], fast_raw};
			slow_rc_sync <= {slow_rc_sync[1:0], internal_slow_rc_osc_in};
			slow_xt_sync <= {slow_xt_sync[1:0], external_slow_crystal_in};
			cfg_sync <= {fast_src_crystal_cfg_in, fast_xtal_high_range_cfg_in};
		end
	end

	// configuration options are caught once, after both sync stages hold them
	logic [1:0] cfg_sync2;
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cfg_sync2 <= 2'h0;
			cfg_hold <= 2'h0;
			cfg_taken <= 1'b0;
			cfg_age <= 2'h0;
		end
		else
		begin
			cfg_sync2 <= cfg_sync;
			cfg_age <= {cfg_age[0], 1'b1}; // fills after two edges
			if (cfg_age[1] && !cfg_taken)
			begin
				cfg_hold <= {cfg_sync2[0], cfg_sync2[1]};
				cfg_taken <= 1'b1;
			end
		end
	end

	// rising edges of the synchronised oscillators become tick enables
	wire fast_tick = fast_sync[1] & ~fast_sync[2];
	wire slow_is_xtal = (slow_sel.code == CODE_SLOW_XTAL);
	wire slow_rc_tick = slow_rc_sync[1] & ~slow_rc_sync[2];
	wire slow_xt_tick = slow_xt_sync[1] & ~slow_xt_sync[2];
	wire slow_tick = slow_is_xtal ? slow_xt_tick : slow_rc_tick;
	// slow clock runs through idle, stops in deep sleep and while the slow source is not ready
	wire slow_en = slow_tick & slow_ready & ~deep_sleep_in;

	// register bus decode
	wire bus_setup = psel_in & ~penable_in;
	wire bus_access = psel_in & penable_in;
	wire hit_slow = (paddr_in == SLOW_SEL_ADDR);
	wire hit_mode = (paddr_in == SYS_MODE_ADDR);
	wire hit_cfg = (paddr_in == CFG_STAT_ADDR);
	wire hit_any = hit_slow | hit_mode | hit_cfg;
	wire wr_slow = bus_access & pwrite_in & hit_slow;
	wire wr_mode = bus_access & pwrite_in & hit_mode;
	wire [6:0] wr_code = pwdata_in[6:0];
	wire code_ok = (wr_code == CODE_SLOW_RC) | (wr_code == CODE_SLOW_XTAL);

	// read data assembled from register and live state
	wire [7:0] mode_view = {sys_mode.divider, 1'b0, slow_ready, fast_ready,
		sys_mode.idle_en, sys_mode.fast_sel};
	wire [7:0] cfg_view = {4'h0, fast_crystal_pins_gpio_out,
		slow_crystal_pins_gpio_out, cfg_hold[1], cfg_hold[0]};
	wire [7:0] rd_byte = hit_slow ? slow_sel : (hit_mode ? mode_view
		: (hit_cfg ? cfg_view : 8'h00));

	assign pready_out = 1'b1;
	assign pslverr_out = bus_access & ~hit_any;

	// read data is captured in the setup cycle, answered with no wait
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			prdata_out <= 32'h0000_0000;
		else if (bus_setup)
			prdata_out <= {24'h00_0000, rd_byte};
	end

	// software registers; an invalid slow code keeps the old one
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			slow_sel <= SLOW_SEL_RESET;
			sys_mode <= {DIVIDER_RESET, IDLE_EN_RESET, FAST_SEL_RESET};
			device_reset_req_out <= 1'b0;
		end
		else
		begin
			device_reset_req_out <= wr_slow & ~code_ok;
			if (wr_slow && code_ok)
				slow_sel <= pwdata_in[7:0];
			if (wr_mode)
			begin
				sys_mode.divider <= pwdata_in[DIV_LSB+2:DIV_LSB];
				sys_mode.idle_en <= pwdata_in[IDLE_EN_POS];
				sys_mode.fast_sel <= pwdata_in[FAST_SEL_POS];
			end
		end
	end

	// slow ready counter restarts on deep sleep or slow source change
	wire [10:0] ready_need = slow_is_xtal ? XTAL_READY_TICKS
		: RC_READY_TICKS;
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ready_cnt <= 11'h000;
			slow_ready <= 1'b0;
			last_code <= SLOW_SEL_RESET[6:0];
		end
		else
		begin
			last_code <= slow_sel.code;
			if (deep_sleep_in || last_code != slow_sel.code)
			begin
				ready_cnt <= 11'h000;
				slow_ready <= 1'b0;
			end
			else if (slow_tick && !slow_ready)
			begin
				ready_cnt <= ready_cnt + 11'h001;
				slow_ready <= (ready_cnt + 11'h001 >= ready_need);
			end
		end
	end

	// fast ready after a few fast ticks
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fast_cnt <= 4'h0;
			fast_ready <= 1'b0;
		end
		else if (fast_tick && !fast_ready)
		begin
			fast_cnt <= fast_cnt + 4'h1;
			fast_ready <= (fast_cnt + 4'h1 == FAST_READY_TICKS);
		end
	end

	// switching: new choice applied once its source is ready, at a boundary of the old clock, or at once if the old clock is not ready
	clk_choice_s wanted;
	assign wanted = choice_of(sys_mode);
	wire fast_pulse = fast_tick & (div_cnt == div_limit(active));
	wire cur_pulse = active.slow ? slow_en : fast_pulse;
	wire cur_dead = active.slow ? ~slow_ready : ~fast_ready;
	wire target_ok = wanted.slow ? slow_ready : fast_ready;
	wire do_switch = (wanted != active) & (cur_pulse | cur_dead) & target_ok;

	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			active <= {1'b0, 3'h0};
			div_cnt <= 6'h00;
		end
		else if (do_switch)
		begin
			active <= wanted;
			div_cnt <= 6'h00; // restart the new period in full
		end
		else if (fast_tick)
			div_cnt <= fast_pulse ? 6'h00 : div_cnt + 6'h01;
	end

	// clock enables and pin roles
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sys_clk_en_out <= 1'b0;
			slow_clk_en_out <= 1'b0;
		end
		else
		begin
			sys_clk_en_out <= cur_pulse & ~cpu_halt_in;
			slow_clk_en_out <= slow_en;
		end
	end

	assign fast_crystal_pins_gpio_out = ~cfg_hold[0];
	assign fast_xtal_high_range_out = cfg_hold[1];
	assign slow_crystal_pins_gpio_out = ~slow_is_xtal;
	assign slow_crystal_low_power_out = slow_sel.low_power;

	// checks
	sequence bad_code_write;
		wr_slow && !code_ok;
	endsequence

	sequence good_code_write;
		wr_slow && code_ok;
	endsequence

	a_bad_code_reset: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		bad_code_write |=> device_reset_req_out && $stable(slow_sel))
		else $error("invalid slow code did not request reset");

	a_good_code_store: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		good_code_write |=> !device_reset_req_out
			&& slow_sel == $past(pwdata_in[7:0]))
		else $error("valid slow code not stored");

	a_one_slow_src: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		slow_sel.code == CODE_SLOW_RC || slow_sel.code == CODE_SLOW_XTAL)
		else $error("slow source code names no oscillator");

	a_ready_sleep_low: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		deep_sleep_in |=> !slow_ready && !slow_clk_en_out)
		else $error("slow ready high after deep sleep");

	a_rc_ready_fast: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(!slow_is_xtal && slow_ready && !$past(slow_ready))
			|-> ready_cnt == RC_READY_TICKS)
		else $error("rc ready after wrong tick count");

	a_xt_ready_late: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(slow_is_xtal && slow_ready && !$past(slow_ready))
			|-> ready_cnt == XTAL_READY_TICKS)
		else $error("crystal ready after wrong tick count");

	a_slow_en_valid: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		slow_clk_en_out |-> $past(slow_ready))
		else $error("slow clock enabled before ready");

	a_slow_in_halt: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(cpu_halt_in && !deep_sleep_in && slow_tick && slow_ready)
			|=> slow_clk_en_out && !sys_clk_en_out)
		else $error("slow clock lost while halted");

	a_switch_clean: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(active != $past(active)) |-> div_cnt == 6'h00
			&& ($past(cur_pulse) || $past(cur_dead)))
		else $error("clock source changed mid period");

	a_div_period: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(!active.slow && fast_tick && !do_switch)
			|-> div_cnt <= div_limit(active))
		else $error("fast divider beyond its limit");

	a_slow_pins: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		good_code_write |=> slow_crystal_pins_gpio_out
			== ($past(pwdata_in[6:0]) != CODE_SLOW_XTAL))
		else $error("slow crystal pin role wrong");

	a_low_power_bit: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		good_code_write |=> slow_crystal_low_power_out
			== $past(pwdata_in[LOW_POWER_POS]))
		else $error("low power bit not applied");

	a_cfg_frozen: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		cfg_taken |=> $stable(cfg_hold))
		else $error("static clock option changed after capture");

	a_reset_pulse: assert property (
		@(posedge core_clk_in) disable iff (!rst_n_in)
		device_reset_req_out |=> !device_reset_req_out)
		else $error("reset request longer than one cycle");

endmodule : clk_source_select

/* File: tb/system_clock_source_select_tb.sv */
// self-checking testbench of the clock source selector
`timescale 1ns/10ps
module system_clock_source_select_tb;
	import clk_select_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr, sys_en, slow_en, fpins, frange;
	logic spins, slow_lp, rst_req;
	logic fcfg = 1'b0;
	logic rcfg = 1'b1;
	logic fast_rc = 1'b0;
	logic fast_xtal = 1'b0;
	logic slow_rc = 1'b0;
	logic slow_xtal = 1'b0;
	logic halt = 1'b0;
	logic deep_sleep = 1'b0;
	int cyc = 0;
	int x_cnt = 0;
	int n_errors = 0;
	int n_checks = 0;

	clk_source_select dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.internal_fast_rc_osc_in(fast_rc), .external_fast_crystal_in(fast_xtal),
		.internal_slow_rc_osc_in(slow_rc), .external_slow_crystal_in(slow_xtal),
		.fast_src_crystal_cfg_in(fcfg), .fast_xtal_high_range_cfg_in(rcfg),
		.cpu_halt_in(halt), .deep_sleep_in(deep_sleep),
		.sys_clk_en_out(sys_en), .slow_clk_en_out(slow_en),
		.fast_crystal_pins_gpio_out(fpins), .fast_xtal_high_range_out(frange),
		.slow_crystal_pins_gpio_out(spins),
		.slow_crystal_low_power_out(slow_lp), .device_reset_req_out(rst_req));

	// 125 MHz clock
	always #4 core_clk = ~core_clk;

	// oscillators: fast rc tick every 2 cycles, fast crystal 4, slow rc 8, slow crystal 10
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		fast_rc <= ~fast_rc;
		fast_xtal <= cyc[1];
		slow_rc <= cyc[2];
		x_cnt <= (x_cnt == 9) ? 0 : x_cnt + 1;
		slow_xtal <= (x_cnt < 5);
		if (cyc == 40000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer, waits for pready at the access edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] mode_word(input logic [2:0] d, input logic f);
		sys_mode_s m;
		m = '{divider: d, idle_en: 1'b1, fast_sel: f};
		return {24'h0, m.divider, 3'h0, m.idle_en, m.fast_sel};
	endfunction : mode_word

	// counts pulses of sys (0), slow (1) or reset request (2)
	task automatic count(input int sel, input int cycles, output int n);
		n = 0;
		repeat (cycles)
		begin
			@(negedge core_clk);
			n += int'((sel == 0 ? sys_en : sel == 1 ? slow_en : rst_req) === 1'b1);
		end
	endtask : count

	// cycles between two system clock pulses
	task automatic measure(output int p);
		int i;
		i = 0;
		do
		begin
			@(negedge core_clk);
			i++;
		end
		while (sys_en !== 1'b1 && i < 400);
		p = 0;
		do
		begin
			@(negedge core_clk);
			p++;
		end
		while (sys_en !== 1'b1 && p < 400);
	endtask : measure

	task automatic t_period(input logic [31:0] mode, input int exp);
		logic [31:0] r;
		logic e;
		int p;
		apb(1'b1, SYS_MODE_ADDR, mode, r, e);
		measure(p);
		measure(p);
		check(p, exp);
	endtask : t_period

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		apb(1'b0, SLOW_SEL_ADDR, 32'h0, r, e);
		check(r, 32'h2a);
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r & 32'he3, 32'h03);
		apb(1'b0, CFG_STAT_ADDR, 32'h0, r, e);
		check(r, 32'h0e);
		check({fpins, frange, spins, slow_lp}, 4'b1110);
		apb(1'b0, 12'h00c, 32'h0, r, e);
		check({r, e}, 33'h1);
	endtask : t_reset

	task automatic t_bad_code();
		logic [31:0] r;
		logic e;
		int n;
		apb(1'b1, SLOW_SEL_ADDR, 32'h13, r, e);
		count(2, 4, n);
		check(n, 1);
		apb(1'b0, SLOW_SEL_ADDR, 32'h0, r, e);
		check(r, 32'h2a);
	endtask : t_bad_code

	task automatic t_sleep();
		logic [31:0] r;
		logic e;
		int n;
		@(posedge core_clk);
		deep_sleep <= 1'b1;
		count(1, 40, n);
		count(1, 40, n);
		check(n, 0);
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r[3], 0);
		@(posedge core_clk);
		deep_sleep <= 1'b0;
		count(1, 40, n);
		check(n > 0, 1);
		@(posedge core_clk);
		halt <= 1'b1;
		count(0, 4, n);
		count(0, 40, n);
		check(n, 0);
		count(1, 40, n);
		check(n > 0, 1);
		@(posedge core_clk);
		halt <= 1'b0;
		count(0, 40, n);
		check(n > 0, 1);
	endtask : t_sleep

	task automatic t_crystal();
		logic [31:0] r;
		logic e;
		int n;
		apb(1'b1, SYS_MODE_ADDR, mode_word(3'h0, 1'b1), r, e);
		apb(1'b1, SLOW_SEL_ADDR, 32'h55, r, e);
		@(negedge core_clk);
		check({spins, slow_lp}, 2'b00);
		repeat (8000) @(posedge core_clk);
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r[3], 0);
		repeat (2500) @(posedge core_clk);
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r[3], 1);
		t_period(mode_word(3'h0, 1'b0), 10);
		apb(1'b1, SLOW_SEL_ADDR, 32'hd5, r, e);
		@(negedge core_clk);
		check(slow_lp, 1);
		count(1, 40, n);
		check(n > 0, 1);
		apb(1'b1, SLOW_SEL_ADDR, 32'h2a, r, e);
		@(negedge core_clk);
		check({spins, slow_lp}, 2'b10);
	endtask : t_crystal

	// second reset in mid-run with the fast crystal and low range chosen
	task automatic t_fast_xtal();
		logic [31:0] r;
		logic e;
		@(posedge core_clk);
		rst_n <= 1'b0;
		fcfg <= 1'b1;
		rcfg <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r, 32'h03);
		repeat (60) @(posedge core_clk);
		@(negedge core_clk);
		check(fpins, 0);
		check(frange, 0);
		apb(1'b0, CFG_STAT_ADDR, 32'h0, r, e);
		check(r, 32'h05);
		apb(1'b0, SYS_MODE_ADDR, 32'h0, r, e);
		check(r[3:2], 2'b11);
		t_period(mode_word(3'h0, 1'b1), 4);
		t_period(mode_word(3'h7, 1'b0), 8);
	endtask : t_fast_xtal

	// main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		t_reset();
		t_bad_code();
		for (int c = 2; c < 8; c++)
			t_period(mode_word(3'(c), 1'b0), 2 * (256 >> c));
		t_period(mode_word(3'h0, 1'b1), 2);
		t_period(mode_word(3'h0, 1'b0), 8);
		t_period(mode_word(3'h1, 1'b0), 8);
		t_period(mode_word(3'h7, 1'b0), 4);
		t_sleep();
		t_crystal();
		t_fast_xtal();
		print_verdict();
	end
endmodule : system_clock_source_select_tb
